/* File: rtl/pcl_pkg.sv */
// package: constants, types and register map of the parallel loader
// Summary of operation
// - request low restarts; user mode pins high
// - status held low for power-on delay
// - complete low until configuration finished
// - clock still needed for two falls after completion; host drives it
// - width mode picks 8, 16, 32 lines
// - complete rises only after full image
// - loaded option drives init-complete output low
// - complete low within 600 ns of request
// - status low within 600 ns of request
// - status low 268 us min, 1506 max
// - status rises within 1506 us, may stretch
// - one word per rising configuration clock edge
// - internal oscillator init: 175 to 437 us
// - user clock init: 4 periods plus 8576
// - timing assumes no decompression or security
package pcl_pkg;
   // clock and time figures
   localparam int CLK_HZ = 20_000_000;
   localparam int CLK_NS = 1_000_000_000 / CLK_HZ;
   localparam int T_CF2CD_NS = 600;
   localparam int T_CF2ST0_NS = 600;
   localparam int T_STATUS_MIN_US = 268;
   localparam int T_STATUS_MAX_US = 1506;
   localparam int T_CD2UM_US = 175;
   localparam int T_CONFIG_CLOCK_MAX_NS = 10;
   localparam int CD2CU_PERIODS = 4;
   localparam int USR_PERIODS = 8576;
   localparam int INIT_FALLS = 2;
   // derived cycle counts: least times round up, longest round down
   localparam int CF2CD_CYC = T_CF2CD_NS / CLK_NS;
   localparam int CF2ST0_CYC = T_CF2ST0_NS / CLK_NS;
   localparam int STATUS_MIN_CYC =
      (T_STATUS_MIN_US * 1000 + CLK_NS - 1) / CLK_NS;
   localparam int STATUS_MAX_CYC = T_STATUS_MAX_US * 1000 / CLK_NS;
   localparam int CD2UM_CYC = (T_CD2UM_US * 1000 + CLK_NS - 1) / CLK_NS;
   localparam int CD2CU_RAW =
      (CD2CU_PERIODS * T_CONFIG_CLOCK_MAX_NS + CLK_NS - 1) / CLK_NS;
   localparam int CD2CU_CYC = (CD2CU_RAW < 1) ? 1 : CD2CU_RAW;
   localparam int TMR_W = 16;
   // register byte offsets on the bus
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_LENGTH = 8'h04;
   localparam logic [7:0] REG_STATUS = 8'h08;
   localparam logic [7:0] REG_COUNT = 8'h0c;
   localparam logic [7:0] REG_LAST = 8'h10;
   // header word option bits
   localparam int HDR_INIT_BIT = 0;
   localparam int HDR_UCLK_BIT = 1;
   localparam logic [31:0] LENGTH_RST = 32'h0000_0000;
   // sync vector layout
   localparam int SY_DATA = 0;
   localparam int SY_REQ = 32;
   localparam int SY_CONFIG_CLOCK = 33;
   localparam int SY_STAT = 34;
   localparam int SY_UCLK = 35;
   localparam int SY_W = 36;
   localparam logic [SY_W-1:0] SY_RST = 36'h5_0000_0000;

   typedef enum logic [1:0] {
      PCL_W8 = 2'b00,
      PCL_W16 = 2'b01,
      PCL_W32 = 2'b10
   } pcl_width_t;

   typedef enum logic [3:0] {
      PCL_POR = 4'b0000,
      PCL_CFG_RESET = 4'b0001,
      PCL_WAIT_ST = 4'b0010,
      PCL_LOAD = 4'b0011,
      PCL_EDGES = 4'b0100,
      PCL_CU = 4'b0101,
      PCL_INIT = 4'b0110,
      PCL_USER = 4'b0111
   } pcl_state_t;

   // software settings that travel together
   typedef struct packed {
      pcl_width_t width;
      logic [31:0] length;
   } pcl_ctrl_t;

   // open-drain pin drive set
   typedef struct packed {
      logic status_oe_n;
      logic complete_oe_n;
      logic init_oe_n;
      logic user_io;
   } pcl_pins_t;
endpackage

/* File: rtl/pcl_sync.sv */
// three-flop pin synchroniser with agreement filter
`timescale 1ns/1ps
module pcl_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST = '0
) (
   // clock and reset
   input logic hclk,
   input logic hresetn,
   // pins in, filtered level out
   input logic [W-1:0] d,
   output logic [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] q;
   } pcl_sync_s_t;
   pcl_sync_s_t s_q, s_d;

   // a bit changes only once stages two and three agree
   always_comb begin
      s_d.s1 = d;
      s_d.s2 = s_q.s1;
      s_d.s3 = s_q.s2;
      s_d.q = (s_q.s2 & ~(s_q.s2 ^ s_q.s3)) | (s_q.q & (s_q.s2 ^ s_q.s3));
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_q <= {RST, RST, RST, RST};
      end else begin
         s_q <= s_d;
      end
   end

   assign q = s_q.q;
endmodule // pcl_sync

/* File: rtl/pcl_timer.sv */
// loadable down counter with a tick enable
`timescale 1ns/1ps
module pcl_timer #(
   parameter int W = 16,
   parameter logic [W-1:0] RST = '0
) (
   // clock and reset
   input logic hclk,
   input logic hresetn,
   // control
   input logic load,
   input logic [W-1:0] value,
   input logic tick,
   // status
   output logic done
);
   typedef struct packed {
      logic [W-1:0] cnt;
   } pcl_timer_s_t;
   pcl_timer_s_t s_q, s_d;

   // load wins over the tick so a restart is never lost
   always_comb begin
      s_d = s_q;
      if (load) begin
         s_d.cnt = value;
      end else if (tick && s_q.cnt != '0) begin
         s_d.cnt = s_q.cnt - 1'b1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_q <= RST;
      end else begin
         s_q <= s_d;
      end
   end

   assign done = (s_q.cnt == '0);
endmodule // pcl_timer

/* File: rtl/pcl_top.sv */
// fast passive parallel loader, one word per clock, with bus registers
`timescale 1ns/1ps
module pcl_top #(
   parameter int STATUS_MIN = pcl_pkg::STATUS_MIN_CYC,
   parameter int POR_CYC = pcl_pkg::STATUS_MIN_CYC,
   parameter int USR_CNT = pcl_pkg::USR_PERIODS
) (
   // clock and reset
   input logic hclk,
   input logic hresetn,
   // ahb-lite slave
   input logic hsel,
   input logic [31:0] haddr,
   input logic [1:0] htrans,
   input logic hwrite,
   input logic [2:0] hsize,
   input logic [31:0] hwdata,
   input logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   // configuration link pins
   input logic config_request_n,
   input logic config_clock,
   input logic [31:0] config_data,
   input logic user_clock,
   // open-drain status pin
   input logic status_in,
   output logic status_out,
   output logic status_oe_n,
   // open-drain completion pins
   output logic complete_out,
   output logic complete_oe_n,
   output logic init_done_out,
   output logic init_done_oe_n,
   // data lines handed to user logic
   output logic user_io_en
);
   import pcl_pkg::*;

   typedef struct packed {
      pcl_state_t st;
      logic config_clock_q;
      logic uclk_q;
      logic req_q;
      pcl_pins_t pins;
      logic hdr_seen;
      logic opt_init;
      logic opt_uclk;
      logic [1:0] falls;
      logic [31:0] count;
      logic [31:0] last;
      pcl_ctrl_t ctrl;
      logic wr_pend;
      logic [7:0] waddr;
      logic [31:0] rdata;
   } pcl_top_s_t;

   localparam pcl_top_s_t S_RST = '{
      st: PCL_POR, config_clock_q: 1'b0, uclk_q: 1'b0, req_q: 1'b1,
      pins: '{status_oe_n: 1'b0, complete_oe_n: 1'b0,
              init_oe_n: 1'b1, user_io: 1'b0},
      hdr_seen: 1'b0, opt_init: 1'b0, opt_uclk: 1'b0, falls: 2'h0,
      count: 32'h0000_0000, last: 32'h0000_0000,
      ctrl: '{width: PCL_W8, length: LENGTH_RST},
      wr_pend: 1'b0, waddr: 8'h00, rdata: 32'h0000_0000};

   pcl_top_s_t s_q, s_d;
   logic [SY_W-1:0] sy;
   logic req_s, config_clock_s, stat_s, uclk_s;
   logic [31:0] data_s;
   logic st_load, st_done, in_load, in_done, in_tick;
   logic [TMR_W-1:0] st_val, in_val;
   logic acc, req_fall, config_clock_rise, config_clock_fall, uclk_rise;

   // keep only the lines of the selected width
   function automatic logic [31:0] mask_word(pcl_width_t w,
                                             logic [31:0] d);
      case (w)
         PCL_W8: mask_word = {24'h00_0000, d[7:0]};
         PCL_W16: mask_word = {16'h0000, d[15:0]};
         default: mask_word = d;
      endcase
   endfunction

   // all pins cross through one filtered synchroniser
   pcl_sync #(
      .W(SY_W),
      .RST(SY_RST)
   ) u_sync (
      .hclk(hclk),
      .hresetn(hresetn),
      .d({user_clock, status_in, config_clock, config_request_n,
          config_data}),
      .q(sy)
   );

   assign data_s = sy[SY_DATA +: 32];
   assign req_s = sy[SY_REQ];
   assign config_clock_s = sy[SY_CONFIG_CLOCK];
   assign stat_s = sy[SY_STAT];
   assign uclk_s = sy[SY_UCLK];

   // status low-time timer, loaded with the power-on delay at reset
   pcl_timer #(
      .W(TMR_W),
      .RST(TMR_W'(POR_CYC))
   ) u_status_tmr (
      .hclk(hclk),
      .hresetn(hresetn),
      .load(st_load),
      .value(st_val),
      .tick(1'b1),
      .done(st_done)
   );

   // initialisation timer, ticks on hclk or on user clock edges
   pcl_timer #(
      .W(TMR_W),
      .RST('0)
   ) u_init_tmr (
      .hclk(hclk),
      .hresetn(hresetn),
      .load(in_load),
      .value(in_val),
      .tick(in_tick),
      .done(in_done)
   );

   // edges found on the filtered levels
   assign req_fall = s_q.req_q & ~req_s;
   assign config_clock_rise = config_clock_s & ~s_q.config_clock_q;
   assign config_clock_fall = ~config_clock_s & s_q.config_clock_q;
   assign uclk_rise = uclk_s & ~s_q.uclk_q;
   assign acc = hsel & htrans[1] & hready;

   // next state of the loader and the register file
   always_comb begin
      s_d = s_q;
      st_load = 1'b0;
      st_val = TMR_W'(STATUS_MIN);
      in_load = 1'b0;
      in_val = TMR_W'(CD2UM_CYC);
      in_tick = 1'b1;
      s_d.config_clock_q = config_clock_s;
      s_d.uclk_q = uclk_s;
      s_d.req_q = req_s;
      // bus address phase; zero wait states so reads are staged now
      s_d.wr_pend = acc & hwrite;
      s_d.waddr = haddr[7:0];
      if (acc && !hwrite) begin
         case (haddr[7:0])
            REG_CTRL: s_d.rdata = {30'h0, s_q.ctrl.width};
            REG_LENGTH: s_d.rdata = s_q.ctrl.length;
            REG_STATUS: s_d.rdata = {20'h0, s_q.falls, s_q.opt_uclk,
                                     s_q.opt_init, s_q.pins, s_q.st};
            REG_COUNT: s_d.rdata = s_q.count;
            REG_LAST: s_d.rdata = s_q.last;
            default: s_d.rdata = 32'h0000_0000;
         endcase
      end
      // bus data phase writes; an unknown width code falls back to 32
      if (s_q.wr_pend) begin
         case (s_q.waddr)
            REG_CTRL: begin
               case (hwdata[1:0])
                  PCL_W8: s_d.ctrl.width = PCL_W8;
                  PCL_W16: s_d.ctrl.width = PCL_W16;
                  default: s_d.ctrl.width = PCL_W32;
               endcase
            end
            REG_LENGTH: s_d.ctrl.length = hwdata;
            default: ;
         endcase
      end
      case (s_q.st)
         // power-on: status low for the power-on delay
         PCL_POR: begin
            s_d.pins.status_oe_n = 1'b0;
            s_d.pins.complete_oe_n = 1'b0;
            if (st_done) begin
               if (req_s) begin
                  s_d.pins.status_oe_n = 1'b1;
                  s_d.st = PCL_WAIT_ST;
               end else begin
                  st_load = 1'b1;
                  s_d.st = PCL_CFG_RESET;
               end
            end
         end
         // reset cycle; status released only after the least low time
         PCL_CFG_RESET: begin
            if (req_s && st_done) begin
               s_d.pins.status_oe_n = 1'b1;
               s_d.st = PCL_WAIT_ST;
            end
         end
         // another party may hold status low to postpone loading
         PCL_WAIT_ST: begin
            if (stat_s) begin
               s_d.st = PCL_LOAD;
            end
         end
         // one word per rising clock edge while status is high
         PCL_LOAD: begin
            if (config_clock_rise && stat_s) begin
               s_d.last = mask_word(s_q.ctrl.width, data_s);
               s_d.count = s_q.count + 32'h0000_0001;
               if (!s_q.hdr_seen) begin
                  s_d.hdr_seen = 1'b1;
                  s_d.opt_init = data_s[HDR_INIT_BIT];
                  s_d.opt_uclk = data_s[HDR_UCLK_BIT];
               end
               if (s_q.count + 32'h0000_0001 == s_q.ctrl.length) begin
                  s_d.pins.complete_oe_n = 1'b1;
                  s_d.falls = 2'h0;
                  s_d.st = PCL_EDGES;
               end
            end
            if (s_q.hdr_seen && s_q.opt_init) begin
               s_d.pins.init_oe_n = 1'b0;
            end
         end
         // wait for the two extra falling edges, then drop the clock
         PCL_EDGES: begin
            if (config_clock_fall) begin
               s_d.falls = s_q.falls + 2'h1;
               if (s_q.falls + 2'h1 == 2'(INIT_FALLS)) begin
                  in_load = 1'b1;
                  if (s_q.opt_uclk) begin
                     in_val = TMR_W'(CD2CU_CYC);
                     s_d.st = PCL_CU;
                  end else begin
                     in_val = TMR_W'(CD2UM_CYC);
                     s_d.st = PCL_INIT;
                  end
               end
            end
         end
         // user clock not enabled until the least gap has passed
         PCL_CU: begin
            if (in_done) begin
               in_load = 1'b1;
               in_val = TMR_W'(USR_CNT);
               s_d.st = PCL_INIT;
            end
         end
         // init count runs on user clock edges when that option is on
         PCL_INIT: begin
            in_tick = s_q.opt_uclk ? uclk_rise : 1'b1;
            if (in_done) begin
               s_d.pins.init_oe_n = 1'b1;
               s_d.pins.user_io = 1'b1;
               s_d.st = PCL_USER;
            end
         end
         // user mode: config clock and data are ignored
         PCL_USER: ;
         default: s_d.st = PCL_POR;
      endcase
      // a falling request restarts from anywhere after power-on
      if (req_fall && s_q.st != PCL_POR) begin
         st_load = 1'b1;
         s_d.st = PCL_CFG_RESET;
         s_d.pins.status_oe_n = 1'b0;
         s_d.pins.complete_oe_n = 1'b0;
         s_d.pins.init_oe_n = 1'b1;
         s_d.pins.user_io = 1'b0;
         s_d.count = 32'h0000_0000;
         s_d.hdr_seen = 1'b0;
         s_d.opt_init = 1'b0;
         s_d.opt_uclk = 1'b0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_q <= S_RST;
      end else begin
         s_q <= s_d;
      end
   end

   // outputs; open-drain pins only ever pull low
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = s_q.rdata;
   assign status_out = 1'b0;
   assign complete_out = 1'b0;
   assign init_done_out = 1'b0;
   assign status_oe_n = s_q.pins.status_oe_n;
   assign complete_oe_n = s_q.pins.complete_oe_n;
   assign init_done_oe_n = s_q.pins.init_oe_n;
   assign user_io_en = s_q.pins.user_io;

   // helper: cycles the status pin has been driven low
   localparam int A_CF = CF2CD_CYC;
   localparam int A_ST = CF2ST0_CYC;
   logic [TMR_W:0] low_cnt_q;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         low_cnt_q <= '0;
      end else if (status_oe_n) begin
         low_cnt_q <= '0;
      end else if (low_cnt_q != '1) begin
         low_cnt_q <= low_cnt_q + 1'b1;
      end
   end

   property p_req_complete;
      @(posedge hclk) disable iff (!hresetn)
      $fell(req_s) && s_q.st != PCL_POR |-> ##[1:A_CF] !complete_oe_n;
   endproperty
   a_req_complete: assert property (p_req_complete)
      else $error("complete not low after request");

   property p_req_status;
      @(posedge hclk) disable iff (!hresetn)
      $fell(req_s) && s_q.st != PCL_POR |-> ##[1:A_ST] !status_oe_n;
   endproperty
   a_req_status: assert property (p_req_status)
      else $error("status not low after request");

   property p_status_min;
      @(posedge hclk) disable iff (!hresetn)
      $rose(status_oe_n) && $past(s_q.st) == PCL_CFG_RESET
         |-> $past(low_cnt_q) >= (TMR_W+1)'(STATUS_MIN);
   endproperty
   a_status_min: assert property (p_status_min)
      else $error("status low pulse too short");

   property p_loading_complete_low;
      @(posedge hclk) disable iff (!hresetn)
      s_q.st inside {PCL_POR, PCL_CFG_RESET, PCL_WAIT_ST, PCL_LOAD}
         |-> !complete_oe_n;
   endproperty
   a_loading_complete_low: assert property (p_loading_complete_low)
      else $error("complete released during loading");

   property p_complete_full;
      @(posedge hclk) disable iff (!hresetn)
      $rose(complete_oe_n) |-> s_q.count == s_q.ctrl.length
         && $past(config_clock_rise);
   endproperty
   a_complete_full: assert property (p_complete_full)
      else $error("complete before whole image");

   property p_word_window;
      @(posedge hclk) disable iff (!hresetn)
      s_q.count != $past(s_q.count) && s_q.count != '0
         |-> $past(s_q.st) == PCL_LOAD && $past(stat_s)
         && s_q.count == $past(s_q.count) + 32'h0000_0001;
   endproperty
   a_word_window: assert property (p_word_window)
      else $error("word taken outside loading window");

   property p_init_option;
      @(posedge hclk) disable iff (!hresetn)
      s_q.st == PCL_LOAD && s_q.hdr_seen && s_q.opt_init
         |=> s_q.st != PCL_USER && !init_done_oe_n
         || s_q.st == PCL_CFG_RESET;
   endproperty
   a_init_option: assert property (p_init_option)
      else $error("init output not driven low");

   property p_user_mode;
      @(posedge hclk) disable iff (!hresetn)
      s_q.st == PCL_USER |-> status_oe_n && complete_oe_n
         && init_done_oe_n && user_io_en;
   endproperty
   a_user_mode: assert property (p_user_mode)
      else $error("user mode pins not released");

   property p_user_after_edges;
      @(posedge hclk) disable iff (!hresetn)
      $rose(user_io_en) |-> $past(s_q.st) == PCL_INIT
         && s_q.falls == 2'(INIT_FALLS);
   endproperty
   a_user_after_edges: assert property (p_user_after_edges)
      else $error("user mode without two falling edges");
endmodule // pcl_top

/* File: tb/pcl_host.sv */
// behavioural configuration host driving the loader's link pins
`timescale 1ns/1ps
module pcl_host #(
   parameter int HALF = 4
) (
   // clock
   input logic hclk,
   // link pins
   output logic config_request_n,
   output logic config_clock,
   output logic [31:0] config_data,
   output logic user_clock,
   // open-drain status wire
   input logic status_in,
   output logic hold_low
);
   // idle levels: clock parked low, never left floating
   initial begin
      config_request_n = 1'b1;
      config_clock = 1'b0;
      config_data = 32'h0;
      user_clock = 1'b0;
      hold_low = 1'b0;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge hclk);
   endtask

   // request pin level; the caller times the low pulse
   task automatic drive_request(input logic v);
      config_request_n <= v;
   endtask

   // pulling the wire low postpones loading, which is allowed
   task automatic hold_status(input logic v);
      hold_low <= v;
   endtask

   // host watches status, then waits 2 us before the first rising edge
   task automatic wait_ready(output bit ok);
      for (int i = 0; i < 200 && status_in !== 1'b1; i++) begin
         tick(1);
      end
      ok = (status_in === 1'b1);
      tick(40);
   endtask

   // one word per 400 ns period; lines flip once hold time has run out
   task automatic send_word(input logic [31:0] w);
      config_data <= w;
      tick(2);
      config_clock <= 1'b1;
      tick(HALF);
      config_clock <= 1'b0;
      tick(1);
      config_data <= ~w;
      tick(1);
   endtask

   // extra falling edges after completion, then clock parked low
   task automatic send_falls(input int n);
      repeat (n) begin
         config_clock <= 1'b1;
         tick(HALF);
         config_clock <= 1'b0;
         tick(HALF);
      end
   endtask

   // clock parked at either level once loading is over
   task automatic park_clock(input logic v);
      config_clock <= v;
   endtask

   // user initialisation clock, stands still between bursts
   task automatic user_pulses(input int n);
      repeat (n) begin
         user_clock <= 1'b1;
         tick(HALF);
         user_clock <= 1'b0;
         tick(HALF);
      end
   endtask
endmodule // pcl_host

/* File: tb/test_parallel_config_loader_ratio1.sv */
// self-checking bench: bus master, link host and a queue model
`timescale 1ns/1ps
module test_parallel_config_loader_ratio1;
   import pcl_pkg::*;
   localparam int SMIN = 60;
   localparam int POR = 20;
   localparam int USR = 8;
   localparam int WID[3] = '{0, 1, 2};
   localparam int LENS[3] = '{5, 6, 4};
   localparam int SENT[3] = '{5, 3, 4};
   localparam int OPT[3] = '{3, 0, 1};
   logic hclk = 1'b0;
   logic hresetn, hsel, hwrite, hready, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, config_data;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic config_request_n, config_clock, user_clock, status_in;
   logic status_out, status_oe_n, complete_out, complete_oe_n;
   logic init_done_out, init_done_oe_n, user_io_en, hold_low;
   logic [3:0] obs;
   logic [31:0] exp_q[$];
   int bad_count = 0;
   int num_checks = 0;
   int seed = 32'h60e4;

   // 50 ns clock; the single slave's ready is the bus ready
   always #25 hclk = ~hclk;
   assign hready = hreadyout;
   // pulled-up wire: device or host may pull it low
   assign status_in = (status_oe_n | status_out) & ~hold_low;
   assign obs = {user_io_en, init_done_oe_n, complete_oe_n, status_oe_n};

   pcl_top #(.STATUS_MIN(SMIN), .POR_CYC(POR), .USR_CNT(USR)) u_pcl_top (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
      .hresp(hresp), .config_request_n(config_request_n),
      .config_clock(config_clock), .config_data(config_data),
      .user_clock(user_clock), .status_in(status_in),
      .status_out(status_out), .status_oe_n(status_oe_n),
      .complete_out(complete_out), .complete_oe_n(complete_oe_n),
      .init_done_out(init_done_out), .init_done_oe_n(init_done_oe_n),
      .user_io_en(user_io_en));

   pcl_host u_pcl_host (
      .hclk(hclk), .config_request_n(config_request_n),
      .config_clock(config_clock), .config_data(config_data),
      .user_clock(user_clock), .status_in(status_in),
      .hold_low(hold_low));

   task automatic give_verdict();
      if (bad_count == 0 && num_checks > 0) begin
         $display("NO MISMATCHES");
      end
      else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // bounded wait for hready sampled high at a rising edge
   task automatic wait_rdy();
      int i;
      i = 0;
      do begin
         @(posedge hclk);
         i++;
      end while (hready !== 1'b1 && i < 50);
      if (hready !== 1'b1) begin
         bad_count++;
         give_verdict();
      end
   endtask

   // single word transfer: address phase, then data phase
   task automatic bus(input logic wr, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] rd);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'b10;
      hwrite <= wr;
      hsize <= 3'b010;
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      wait_rdy();
      rd = hrdata;
   endtask

   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] rd;
      bus(1'b0, a, 32'h0, rd);
      chk(rd, exp);
   endtask

   // bounded wait for one pin flag to reach a level
   task automatic wait_obs(input int b, input logic v, input int lim,
                           output int n);
      n = 0;
      while (obs[b] !== v && n < lim) begin
         @(posedge hclk);
         n++;
      end
      if (obs[b] !== v) begin
         bad_count++;
         give_verdict();
      end
   endtask

   // watchdog: a hang counts as a mismatch
   initial begin
      repeat (100000) @(posedge hclk);
      bad_count++;
      give_verdict();
   end

   // main sequence: reset, registers, then three configuration frames
   initial begin
      logic [31:0] rd, w, mask;
      int n, k;
      bit ok;
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = 32'h0;
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      chk({28'h0, obs}, 32'h4);
      wait_obs(0, 1'b1, POR + 40, n);
      chk({31'h0, n >= POR - 1}, 32'h1);
      rchk(REG_LENGTH, LENGTH_RST);
      bus(1'b1, 8'h24, 32'hffff_ffff, rd);
      rchk(8'h24, 32'h0);
      for (int i = 0; i < 4; i++) begin
         bus(1'b1, REG_CTRL, i, rd);
         rchk(REG_CTRL, (i == 3) ? 2 : i);
      end
      for (int e = 0; e < 3; e++) begin
         bus(1'b1, REG_CTRL, WID[e], rd);
         bus(1'b1, REG_LENGTH, LENS[e], rd);
         mask = (WID[e] == 0) ? 32'hff :
                (WID[e] == 1) ? 32'hffff : 32'hffff_ffff;
         exp_q.delete();
         u_pcl_host.drive_request(1'b0);
         n = 0;
         while (n < 13 && obs[1:0] !== 2'b00) begin
            @(posedge hclk);
            n++;
         end
         chk({30'h0, obs[1:0]}, 32'h0);
         repeat (40 - n) @(posedge hclk);
         u_pcl_host.drive_request(1'b1);
         wait_obs(0, 1'b1, 100, k);
         chk({31'h0, 40 + k >= SMIN && 40 + k <= SMIN + 14}, 32'h1);
         rchk(REG_COUNT, 32'h0);
         // edges while the wire is held low must not load anything
         if (e == 0) begin
            u_pcl_host.hold_status(1'b1);
            repeat (8) @(posedge hclk);
            repeat (2) u_pcl_host.send_word($random(seed));
            rchk(REG_COUNT, 32'h0);
            u_pcl_host.hold_status(1'b0);
         end
         u_pcl_host.wait_ready(ok);
         chk({31'h0, ok}, 32'h1);
         for (int i = 0; i < SENT[e]; i++) begin
            w = $random(seed);
            if (i == 0) w[1:0] = OPT[e];
            u_pcl_host.send_word(w);
            exp_q.push_back(w & mask);
            repeat (4) @(posedge hclk);
            rchk(REG_COUNT, exp_q.size());
            rchk(REG_LAST, exp_q[$]);
            chk({31'h0, complete_oe_n}, exp_q.size() == LENS[e]);
            chk({31'h0, init_done_oe_n}, !OPT[e][0]);
         end
         // aborted frame: the next request restarts loading
         if (SENT[e] < LENS[e]) continue;
         u_pcl_host.send_falls(2);
         if (OPT[e][1]) begin
            repeat (10) @(posedge hclk);
            u_pcl_host.user_pulses(USR - 1);
            chk({31'h0, user_io_en}, 32'h0);
            u_pcl_host.user_pulses(1);
            wait_obs(3, 1'b1, 20, k);
         end
         else begin
            repeat (3400) @(posedge hclk);
            chk({31'h0, user_io_en}, 32'h0);
            wait_obs(3, 1'b1, 400, k);
         end
         chk({28'h0, obs}, 32'hf);
         chk({29'h0, hresp, complete_out, init_done_out}, 32'h0);
         bus(1'b0, REG_STATUS, 32'h0, rd);
         chk(rd & 32'hf, {28'h0, PCL_USER});
         w = $random(seed);
         u_pcl_host.park_clock(w[0]);
         u_pcl_host.send_word($random(seed));
         rchk(REG_COUNT, exp_q.size());
      end
      give_verdict();
   end
endmodule // test_parallel_config_loader_ratio1
